// ---- bench/bc_blink_diag_sva.sv ----
// checker: port assertions of the blink code diagnostic block
`timescale 1ns/1ns
module bc_blink_diag_sva #(
  parameter int unsigned ON_CYC = 5
) (
  input wire logic              mclk_in,
  input wire logic              rst_b_in,
  input wire logic              warn_req_in,
  input wire logic              wheel_speed_valid_in,
  input wire logic [1:0]        axle_zero_speed_in,
  input wire logic              tool_test_req_in,
  input wire logic              tool_clear_req_in,
  input wire logic              lamp_out,
  input wire logic              test_enable_out,
  input wire bc_pkg::bc_fault_t stored_faults_out,
  input wire logic              blink_busy_out,
  input wire logic              codes_cleared_out
);
  import bc_pkg::*;
  logic [31:0] on_run_ff;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_run_ff <= TMR_RST;
    end else begin
      on_run_ff <= lamp_out ? on_run_ff + 32'h1 : TMR_RST;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_TEST_BLOCK: assert property (
    tool_test_req_in && axle_zero_speed_in == 2'h0 |=> !test_enable_out)
    else $error("output test allowed while no axle is stopped");
  AST_TEST_GRANT: assert property (
    tool_test_req_in && (|axle_zero_speed_in) |=> test_enable_out)
    else $error("output test refused with a stopped axle");
  AST_TOOL_CLEAR: assert property (
    tool_clear_req_in |=> codes_cleared_out)
    else $error("tool clear gave no clear pulse");
  AST_LEAD_DARK: assert property (
    $rose(blink_busy_out) |-> !lamp_out [*8])
    else $error("lamp lit during lead-in");
  AST_ON_WIDTH: assert property (
    $fell(lamp_out) && blink_busy_out && $past(blink_busy_out) |-> on_run_ff == 32'(ON_CYC))
    else $error("flash on time wrong");
  AST_NORMAL_LAMP: assert property (
    $past(rst_b_in) && !blink_busy_out && !$past(blink_busy_out) && $past(warn_req_in)
      |-> lamp_out)
    else $error("warning request not shown on lamp");
  AST_HIST_KEEP: assert property (
    ($past(stored_faults_out) & ~stored_faults_out) != 6'h00 |->
      ($past(codes_cleared_out) || $past(codes_cleared_out, 2)) or ##[0:2] codes_cleared_out)
    else $error("stored fault lost without a clear");
  AST_SENSOR_LATCH: assert property (
    codes_cleared_out && !blink_busy_out && $past(stored_faults_out.sensor, 3) != 4'h0
      && !wheel_speed_valid_in |-> ##2 (lamp_out || $past(wheel_speed_valid_in)) [*6])
    else $error("lamp not held after sensor clear");
endmodule
bind bc_blink_diag bc_blink_diag_sva #(.ON_CYC(ON_CYC)) u_sva (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .warn_req_in(warn_req_in),
  .wheel_speed_valid_in(wheel_speed_valid_in), .axle_zero_speed_in(axle_zero_speed_in),
  .tool_test_req_in(tool_test_req_in), .tool_clear_req_in(tool_clear_req_in),
  .lamp_out(lamp_out), .test_enable_out(test_enable_out),
  .stored_faults_out(stored_faults_out), .blink_busy_out(blink_busy_out),
  .codes_cleared_out(codes_cleared_out)
);

// ---- bench/bc_jumper_model.sv ----
// partner model: technician jumper on connector pins or ground bullet
`timescale 1ns/1ns
module bc_jumper_model (
  input  wire logic mclk_in,
  output logic      pins_out,
  output logic      bullet_b_out
);
  initial begin
    pins_out = 1'b0;
    bullet_b_out = 1'b1;
  end
  task automatic apply(input bit blt);
    if (blt) begin
      bullet_b_out = 1'b0;
    end else begin
      pins_out = 1'b1;
    end
  endtask
  // open pins read low, bullet pulled up
  task automatic remove();
    pins_out = 1'b0;
    bullet_b_out = 1'b1;
  endtask
  task automatic press(input int cyc, input bit blt);
    apply(blt);
    repeat (cyc) @(posedge mclk_in);
    #1;
    remove();
  endtask
endmodule

// ---- bench/tb_bc_blink_diag.sv ----
// testbench: blink code retrieval, clearing, lamp latch and test interlock
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
  total_checks++; \
  if ((gt) !== (ex)) begin \
    failures++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module tb_bc_blink_diag;
  import bc_pkg::*;
  localparam int unsigned TDIV = 1_000_000;
  localparam int unsigned OFF  = CYC_PER_MS * T_OFF_MS / TDIV;
  localparam int unsigned HMIN = CYC_PER_MS * T_HOLD_MIN_MS / TDIV;
  localparam int unsigned HMAX = CYC_PER_MS * T_HOLD_MAX_MS / TDIV;
  localparam int unsigned CLR  = CYC_PER_MS * T_CLEAR_MS / TDIV;
  localparam bc_fault_t  FLTS [7] = '{6'h00, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  localparam logic [3:0] DIGS [7] = '{FLT_NONE, FLT_VALVE_B, FLT_VALVE_A, FLT_SENSOR_D,
                                      FLT_SENSOR_C, FLT_SENSOR_B, FLT_SENSOR_A};
  logic       mclk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       later = 1'b0;
  logic       ign = 1'b1;
  logic [3:0] cfg = 4'h1;
  bc_fault_t  act = FAULT_RST;
  logic       wheel = 1'b0;
  logic       warn = 1'b0;
  logic [1:0] axle = 2'h0;
  logic       treq = 1'b0;
  logic       creq = 1'b0;
  logic       jp, jb_b, lamp, ten, busy, clrd, hit;
  logic       run = 1'b0;
  bc_fault_t  stored;
  bc_code_t   ex, got;
  bc_code_t   exp_q[$];
  logic [3:0] c0 = 4'h0;
  logic [3:0] c1 = 4'h0;
  bit         grp = 1'b0;
  int         dark = 0;
  int         failures = 0;
  int         total_checks = 0;
  int         i;
  always #10 mclk_in = ~mclk_in;
  bc_jumper_model mdl_u (.mclk_in(mclk_in), .pins_out(jp), .bullet_b_out(jb_b));
  bc_blink_diag #(.TIME_DIV(TDIV)) dut_u (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .jumper_pins_in(jp), .jumper_bullet_b_in(jb_b),
    .later_variant_in(later), .ignition_in(ign), .config_code_in(cfg),
    .active_faults_in(act), .wheel_speed_valid_in(wheel), .warn_req_in(warn),
    .axle_zero_speed_in(axle), .tool_test_req_in(treq), .tool_clear_req_in(creq),
    .lamp_out(lamp), .test_enable_out(ten), .stored_faults_out(stored),
    .blink_busy_out(busy), .codes_cleared_out(clrd));
  // count flashes per group, compare when the sequence ends
  always @(posedge mclk_in) begin
    if (busy === 1'b1) begin
      if (lamp === 1'b1 && dark > 0) begin
        if (dark > OFF && c0 != 4'h0) grp = 1'b1;
        if (grp) c1 = c1 + 4'h1;
        else c0 = c0 + 4'h1;
      end
      dark = (lamp === 1'b1) ? 0 : dark + 1;
      run = 1'b1;
    end else if (run) begin
      got = {c0, c1};
      ex = (exp_q.size() != 0) ? exp_q.pop_front() : CODE_RST;
      `CHK("code", ex, got)
      {c0, c1, grp, dark, run} = '0;
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wait_busy(input logic lvl, input int n);
    for (int k = 0; k < n && busy !== lvl; k++) tick(1);
    if (busy !== lvl) begin
      failures++;
      $display("BAD busy exp %0b got %0b", lvl, busy);
      results();
    end
  endtask
  task automatic retrieve(input bc_code_t e, input bit twice, input bit blt);
    exp_q.push_back(e);
    mdl_u.press(HMIN + 25 + $urandom % 40, blt);
    if (twice) begin
      tick(10);
      mdl_u.press(HMIN + 35, blt);
    end
    wait_busy(1'b1, 100);
    wait_busy(1'b0, 1000);
    tick(2);
  endtask
  task automatic refuse(input int cyc);
    hit = 1'b0;
    mdl_u.press(cyc, 1'b0);
    for (int k = 0; k < 80; k++) begin
      tick(1);
      hit = hit | busy;
    end
    `CHK("refused", 1'b0, hit)
  endtask
  initial begin
    void'($urandom(32'hFD49));
    tick(4);
    rst_b_in = 1'b1;
    tick(40);
    for (i = 0; i < 7; i++) begin
      cfg = (i == 5) ? 4'h3 : 4'($urandom % 4 + 1);
      act = FLTS[i];
      tick(3);
      retrieve({cfg, DIGS[i]}, 1'b0, i[0]);
    end
    $display("test earlier codes done");
    act = FAULT_RST;
    tick(2);
    creq = 1'b1;
    tick(1);
    creq = 1'b0;
    tick(20);
    `CHK("stored", FAULT_RST, stored)
    `CHK("latch", 1'b1, lamp)
    wheel = 1'b1;
    tick(5);
    `CHK("lamp", 1'b0, lamp)
    retrieve({cfg, FLT_NONE}, 1'b0, 1'b0);
    $display("test clear done");
    warn = 1'b1;
    refuse(20);
    refuse(HMAX + 40);
    ign = 1'b0;
    refuse(HMIN + 30);
    ign = 1'b1;
    warn = 1'b0;
    $display("test refusal done");
    treq = 1'b1;
    for (i = 0; i < 4; i++) begin
      axle = 2'(i);
      tick(2);
      `CHK("test_en", |axle, ten)
    end
    treq = 1'b0;
    tick(2);
    `CHK("test_off", 1'b0, ten)
    $display("test interlock done");
    rst_b_in = 1'b0;
    later = 1'b1;
    cfg = 4'h1;
    mdl_u.apply(1'b1);
    tick(4);
    rst_b_in = 1'b1;
    tick(CLR + 50);
    mdl_u.remove();
    hit = 1'b0;
    for (i = 0; i < 40; i++) begin
      tick(1);
      hit = hit | clrd;
    end
    `CHK("pwr_clear", 1'b1, hit)
    retrieve({LATER_FILL_DIGIT, FLT_NONE}, 1'b0, 1'b0);
    retrieve({4'h1, LATER_FILL_DIGIT}, 1'b1, 1'b1);
    act = 6'h10;
    cfg = 4'($urandom % 4 + 1);
    tick(3);
    retrieve({LATER_FILL_DIGIT, FLT_VALVE_A}, 1'b0, 1'b0);
    retrieve({cfg, LATER_FILL_DIGIT}, 1'b1, 1'b0);
    `CHK("pending", 0, exp_q.size())
    $display("test later variant done");
    results();
  end
endmodule

// ---- design/bc_blink_diag.sv ----
// module: jumper decode, blink code sequencer, clear and test interlock
`timescale 1ns/1ns
module bc_blink_diag #(
  parameter int unsigned TIME_DIV     = 1,
  parameter int unsigned DEB_CYC      = bc_pkg::CYC_PER_MS * bc_pkg::T_DEBOUNCE_MS / TIME_DIV,
  parameter int unsigned GUARD_CYC    = bc_pkg::CYC_PER_MS * bc_pkg::T_GUARD_MS / TIME_DIV,
  parameter int unsigned HOLD_MIN_CYC = bc_pkg::CYC_PER_MS * bc_pkg::T_HOLD_MIN_MS / TIME_DIV,
  parameter int unsigned HOLD_MAX_CYC = bc_pkg::CYC_PER_MS * bc_pkg::T_HOLD_MAX_MS / TIME_DIV,
  parameter int unsigned GAP_CYC      = bc_pkg::CYC_PER_MS * bc_pkg::T_GAP_MS / TIME_DIV,
  parameter int unsigned CLEAR_CYC    = bc_pkg::CYC_PER_MS * bc_pkg::T_CLEAR_MS / TIME_DIV,
  parameter int unsigned ON_CYC       = bc_pkg::CYC_PER_MS * bc_pkg::T_ON_MS / TIME_DIV,
  parameter int unsigned OFF_CYC      = bc_pkg::CYC_PER_MS * bc_pkg::T_OFF_MS / TIME_DIV,
  parameter int unsigned PAUSE_CYC    = bc_pkg::CYC_PER_MS * bc_pkg::T_PAUSE_MS / TIME_DIV,
  parameter int unsigned LEAD_CYC     = bc_pkg::CYC_PER_MS * bc_pkg::T_LEAD_MS / TIME_DIV
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic             jumper_pins_in,
  input  wire logic             jumper_bullet_b_in,
  input  wire logic             later_variant_in,
  input  wire logic             ignition_in,
  input  wire logic [3:0]       config_code_in,
  input  wire bc_pkg::bc_fault_t active_faults_in,
  input  wire logic             wheel_speed_valid_in,
  input  wire logic             warn_req_in,
  input  wire logic [1:0]       axle_zero_speed_in,
  input  wire logic             tool_test_req_in,
  input  wire logic             tool_clear_req_in,
  output logic                  lamp_out,
  output logic                  test_enable_out,
  output bc_pkg::bc_fault_t     stored_faults_out,
  output logic                  blink_busy_out,
  output logic                  codes_cleared_out
);
  import bc_pkg::*;
  function automatic logic [3:0] fault_digit(input bc_fault_t f);
    logic [3:0] d;
    d = FLT_NONE;
    if (f.valve[1])  d = FLT_VALVE_B;
    if (f.valve[0])  d = FLT_VALVE_A;
    if (f.sensor[3]) d = FLT_SENSOR_D;
    if (f.sensor[2]) d = FLT_SENSOR_C;
    if (f.sensor[1]) d = FLT_SENSOR_B;
    if (f.sensor[0]) d = FLT_SENSOR_A;
    return d;
  endfunction
  logic [1:0]  pin_meta_ff;
  logic [1:0]  pin_sync_ff;
  logic        strap_meta_ff;
  logic        strap_sync_ff;
  logic [1:0]  strap_age_ff;
  logic        later_ff;
  logic [31:0] deb_cnt_ff;
  logic        jmp_ff;
  bc_jstate_t  js_ff;
  logic [31:0] jtmr_ff;
  logic        start_ff;
  bc_code_t    start_code_ff;
  logic        clear_ff;
  bc_fault_t   stored_ff;
  logic        sensor_latch_ff;
  bc_bstate_t  bs_ff;
  logic [31:0] btmr_ff;
  bc_code_t    code_ff;
  logic        grp_ff;
  logic [3:0]  left_ff;
  logic        clear_any;
  logic        hold_ok;
  bc_fault_t   shown;
  assign clear_any = clear_ff | tool_clear_req_in;
  assign hold_ok   = (jtmr_ff >= HOLD_MIN_CYC) && (jtmr_ff <= HOLD_MAX_CYC);
  assign shown     = stored_ff | active_faults_in;

  // either jumper path counts, bullet grounded reads low
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_ff <= SYNC_RST;
      pin_sync_ff <= SYNC_RST;
    end else begin
      pin_meta_ff <= {~jumper_bullet_b_in, jumper_pins_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // variant strap caught a few cycles after reset release
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
      strap_age_ff  <= SYNC_RST;
      later_ff      <= 1'b0;
    end else begin
      strap_meta_ff <= later_variant_in;
      strap_sync_ff <= strap_meta_ff;
      if (strap_age_ff != STRAP_AGE_DONE) begin
        strap_age_ff <= strap_age_ff + 2'h1;
        later_ff     <= strap_sync_ff;
      end
    end
  end

  // jumper debounce
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      deb_cnt_ff <= TMR_RST;
      jmp_ff     <= 1'b0;
    end else if ((|pin_sync_ff) == jmp_ff) begin
      deb_cnt_ff <= TMR_RST;
    end else if (deb_cnt_ff >= DEB_CYC - 1) begin
      deb_cnt_ff <= TMR_RST;
      jmp_ff     <= |pin_sync_ff;
    end else begin
      deb_cnt_ff <= deb_cnt_ff + 32'h1;
    end
  end

  // jumper pattern decoder
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      js_ff         <= JS_PWRUP;
      jtmr_ff       <= TMR_RST;
      start_ff      <= 1'b0;
      start_code_ff <= CODE_RST;
      clear_ff      <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      clear_ff <= 1'b0;
      if (jtmr_ff != 32'hFFFF_FFFF) begin
        jtmr_ff <= jtmr_ff + 32'h1;
      end
      case (js_ff)
        JS_PWRUP: begin
          if (!jmp_ff && jtmr_ff >= GUARD_CYC) begin
            clear_ff <= (jtmr_ff >= CLEAR_CYC);
            js_ff    <= JS_IDLE;
          end
        end
        JS_IDLE: begin
          jtmr_ff <= TMR_RST;
          if (jmp_ff && ignition_in) begin
            js_ff <= JS_HOLD1;
          end
        end
        JS_HOLD1: begin
          if (!ignition_in) begin
            js_ff <= JS_IDLE;
          end else if (!jmp_ff) begin
            jtmr_ff <= TMR_RST;
            if (!hold_ok) begin
              js_ff <= JS_IDLE;
            end else if (later_ff) begin
              js_ff <= JS_GAP;
            end else begin
              start_ff      <= 1'b1;
              start_code_ff <= {config_code_in, fault_digit(shown)};
              js_ff         <= JS_IDLE;
            end
          end
        end
        JS_GAP: begin
          if (!ignition_in) begin
            js_ff <= JS_IDLE;
          end else if (jmp_ff) begin
            jtmr_ff <= TMR_RST;
            js_ff   <= JS_HOLD2;
          end else if (jtmr_ff >= GAP_CYC) begin
            start_ff      <= 1'b1;
            start_code_ff <= {LATER_FILL_DIGIT, fault_digit(shown)};
            js_ff         <= JS_IDLE;
          end
        end
        JS_HOLD2: begin
          if (!ignition_in) begin
            js_ff <= JS_IDLE;
          end else if (!jmp_ff) begin
            start_ff      <= hold_ok;
            start_code_ff <= {config_code_in, LATER_FILL_DIGIT};
            js_ff         <= JS_IDLE;
          end
        end
        default: begin
          js_ff <= JS_IDLE;
        end
      endcase
    end
  end

  // fault history and sensor lamp latch, setting wins over clearing
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stored_ff       <= FAULT_RST;
      sensor_latch_ff <= 1'b0;
    end else begin
      stored_ff <= clear_any ? active_faults_in : (stored_ff | active_faults_in);
      if (clear_any && (|stored_ff.sensor)) begin
        sensor_latch_ff <= 1'b1;
      end else if (wheel_speed_valid_in) begin
        sensor_latch_ff <= 1'b0;
      end
    end
  end

  // flash sequencer: lead-off, group one, pause, group two
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bs_ff   <= BS_IDLE;
      btmr_ff <= TMR_RST;
      code_ff <= CODE_RST;
      grp_ff  <= 1'b0;
      left_ff <= LEFT_RST;
    end else begin
      btmr_ff <= btmr_ff + 32'h1;
      case (bs_ff)
        BS_IDLE: begin
          btmr_ff <= TMR_RST;
          if (start_ff) begin
            code_ff <= start_code_ff;
            grp_ff  <= 1'b0;
            bs_ff   <= BS_LEAD;
          end
        end
        BS_LEAD: begin
          if (btmr_ff >= LEAD_CYC - 1) begin
            btmr_ff <= TMR_RST;
            left_ff <= code_ff.first;
            bs_ff   <= BS_ON;
          end
        end
        BS_ON: begin
          if (btmr_ff >= ON_CYC - 1) begin
            btmr_ff <= TMR_RST;
            left_ff <= left_ff - 4'h1;
            bs_ff   <= BS_OFF;
          end
        end
        BS_OFF: begin
          if (btmr_ff >= OFF_CYC - 1) begin
            btmr_ff <= TMR_RST;
            if (left_ff != LEFT_RST) begin
              bs_ff <= BS_ON;
            end else if (!grp_ff) begin
              grp_ff <= 1'b1;
              bs_ff  <= BS_PAUSE;
            end else begin
              bs_ff <= BS_IDLE;
            end
          end
        end
        BS_PAUSE: begin
          if (btmr_ff >= PAUSE_CYC - 1) begin
            btmr_ff <= TMR_RST;
            left_ff <= code_ff.second;
            bs_ff   <= BS_ON;
          end
        end
        default: begin
          bs_ff <= BS_IDLE;
        end
      endcase
    end
  end

  // outputs
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lamp_out          <= 1'b0;
      test_enable_out   <= 1'b0;
      stored_faults_out <= FAULT_RST;
      blink_busy_out    <= 1'b0;
      codes_cleared_out <= 1'b0;
    end else begin
      if (bs_ff != BS_IDLE) begin
        lamp_out <= (bs_ff == BS_ON);
      end else begin
        lamp_out <= warn_req_in | sensor_latch_ff | (|active_faults_in);
      end
      test_enable_out   <= tool_test_req_in & (|axle_zero_speed_in);
      stored_faults_out <= stored_ff;
      blink_busy_out    <= (bs_ff != BS_IDLE);
      codes_cleared_out <= clear_any;
    end
  end
endmodule

// ---- design/bc_pkg.sv ----
// package: timing, codes and carrier types of the blink code diagnostic block
package bc_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned T_DEBOUNCE_MS = 20;
  localparam int unsigned T_GUARD_MS    = 100;
  localparam int unsigned T_HOLD_MIN_MS = 1500;
  localparam int unsigned T_HOLD_MAX_MS = 2900;
  localparam int unsigned T_GAP_MS      = 1000;
  localparam int unsigned T_CLEAR_MS    = 3000;
  localparam int unsigned T_ON_MS       = 400;
  localparam int unsigned T_OFF_MS      = 400;
  localparam int unsigned T_PAUSE_MS    = 1500;
  localparam int unsigned T_LEAD_MS     = 1500;

  localparam logic [31:0] TMR_RST  = 32'h0000_0000;
  localparam logic [3:0]  LEFT_RST = 4'h0;
  localparam logic [1:0]  SYNC_RST = 2'h0;
  localparam logic [1:0]  STRAP_AGE_DONE = 2'h3;

  // configuration flash counts
  localparam logic [3:0] CFG_TWO_SENSOR_ONE_MODULATOR  = 4'h1;
  localparam logic [3:0] CFG_TWO_SENSOR_TWO_MODULATOR  = 4'h2;
  localparam logic [3:0] CFG_FOUR_SENSOR_TWO_MOD_SIDE  = 4'h3;
  localparam logic [3:0] CFG_FOUR_SENSOR_TWO_MOD_AXLE  = 4'h4;
  // fault flash counts
  localparam logic [3:0] FLT_NONE     = 4'h1;
  localparam logic [3:0] FLT_SENSOR_A = 4'h2;
  localparam logic [3:0] FLT_SENSOR_B = 4'h3;
  localparam logic [3:0] FLT_SENSOR_C = 4'h4;
  localparam logic [3:0] FLT_SENSOR_D = 4'h5;
  localparam logic [3:0] FLT_VALVE_A  = 4'h8;
  localparam logic [3:0] FLT_VALVE_B  = 4'h9;
  // first digit of later-variant fault code, second digit of later-variant config code
  localparam logic [3:0] LATER_FILL_DIGIT = 4'h1;

  typedef struct packed {
    logic [1:0] valve;   // bit0 valve A, bit1 valve B
    logic [3:0] sensor;  // bit0 sensor A .. bit3 sensor D
  } bc_fault_t;

  typedef struct packed {
    logic [3:0] first;
    logic [3:0] second;
  } bc_code_t;

  localparam bc_fault_t FAULT_RST = 6'h00;
  localparam bc_code_t  CODE_RST  = 8'h00;

  typedef enum logic [4:0] {
    JS_PWRUP = 5'h01,
    JS_IDLE  = 5'h02,
    JS_HOLD1 = 5'h04,
    JS_GAP   = 5'h08,
    JS_HOLD2 = 5'h10
  } bc_jstate_t;

  typedef enum logic [4:0] {
    BS_IDLE  = 5'h01,
    BS_LEAD  = 5'h02,
    BS_ON    = 5'h04,
    BS_OFF   = 5'h08,
    BS_PAUSE = 5'h10
  } bc_bstate_t;
endpackage
